// *** core/mct_pkg.sv ***
// shared constants, states and carriers of the instruction timing core
package mct_pkg;
   localparam logic [1:0]  LEN1          = 2'h1;
   localparam logic [1:0]  LEN2          = 2'h2;
   localparam logic [1:0]  LEN3          = 2'h3;
   localparam logic [3:0]  CYC_ONE       = 4'h1;
   localparam logic [3:0]  CYC_IND       = 4'h2;
   localparam logic [3:0]  MUL_CYC       = 4'h4;
   localparam logic [3:0]  DIV_CYC       = 4'h8;
   localparam logic [3:0]  MAX_CYC       = 4'h8;
   localparam logic [7:0]  OP_MUL        = 8'hA4;
   localparam logic [7:0]  OP_DIV        = 8'h84;
   localparam int          RAM_BYTES     = 256;
   localparam int          RAM_AW        = 8;
   localparam int          SFR_BYTES     = 128;
   localparam int          SFR_BIT       = 7;
   localparam logic [15:0] XRAM_TOP      = 16'h1000;

   typedef enum logic [1:0] {
      MCT_IDLE = 2'b00,
      MCT_EXEC = 2'b01,
      MCT_HALT = 2'b10
   } mct_state_t;

   typedef enum logic [1:0] {
      MCT_XT_NONE  = 2'b00,
      MCT_XT_XRAM  = 2'b01,
      MCT_XT_EXT   = 2'b10,
      MCT_XT_FLASH = 2'b11
   } mct_xtgt_t;

   typedef struct packed {
      logic [1:0] len;
      logic [3:0] cyc;
      logic       cond;
   } mct_insn_t;
endpackage

// *** core/mct_ram256.sv ***
// internal data RAM with registered read port
`timescale 1ns/1ps
module mct_ram256
   import mct_pkg::*;
(
   input  wire logic              clk,    // system clock
   input  wire logic              we,     // write strobe
   input  wire logic [RAM_AW-1:0] addr,   // byte address
   input  wire logic [7:0]        wdata,  // write byte
   output logic       [7:0]       rdata_r // read byte, one cycle after addr
);
   logic [7:0] mem [RAM_BYTES];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_r <= mem[addr];
   end
endmodule

// *** core/mct_core_timing.sv ***
// instruction timing sequencer, data memory and address decode of the core
// Overview of operation
// - every opcode of the standard set is classified with its own encoding, length and flag effects unchanged.
// - time is counted in plain system clocks with no machine-cycle grouping.
// - most instructions finish in as many clocks as they have bytes.
// - an untaken conditional branch takes exactly one clock less than the taken one.
// - no instruction runs longer than eight clocks.
// - the timing classes cover all instructions in one, two, three, four or eight clocks.
// - the core runs at any clock up to the top rate and can start one instruction every clock.
// - there are 256 bytes of data RAM and a 128-byte special-function space.
// - software reads flash bytewise by code moves and changes it bytewise by external-data moves.
// - debug halts, steps, breaks, watches and reaches memory without using core resources.
// - the debug and flash access arrive from a serial test-port host.
// - external-data moves go to on-chip RAM or off-chip memory by address decode, or to program flash when FLASH_MAP_EN is set.
`timescale 1ns/1ps
module mct_core_timing
   import mct_pkg::*;
(
   input  wire logic        SYS_CLK,       // system clock
   input  wire logic        RST_B,         // synchronous reset, active low
   input  wire logic        OP_VALID,      // first opcode byte offered
   input  wire logic [7:0]  OP_CODE,       // opcode byte
   input  wire logic [15:0] FETCH_PC,      // address of the offered opcode
   input  wire logic        COND_TAKEN,    // branch condition holds, with OP_VALID
   output logic             OP_READY,      // opcode taken this cycle when valid
   output logic             INSN_DONE,     // last clock of the running instruction
   output mct_insn_t        INSN_INFO,     // length, clocks and branch class of it
   output logic             BUSY,          // an instruction is running
   input  wire logic        DATA_EN,       // core data access
   input  wire logic        DATA_WE,       // core data write
   input  wire logic        DATA_DIRECT,   // direct addressing mode
   input  wire logic [7:0]  DATA_ADDR,     // data address
   input  wire logic [7:0]  DATA_WDATA,    // data write byte
   output logic      [7:0]  DATA_RDATA,    // RAM read byte
   output logic             SFR_SEL,       // access of the previous clock went to the SFR space
   input  wire logic        XDATA_REQ,     // external-data move
   input  wire logic [15:0] XDATA_ADDR,    // its address
   input  wire logic        FLASH_MAP_EN,  // external-data moves reach flash
   input  wire logic        CODE_REQ,      // code-read move
   output mct_xtgt_t        XTGT,          // target of the last move
   input  wire logic        DBG_HALT,      // debugger holds the core
   input  wire logic        DBG_STEP,      // one-instruction step request
   input  wire logic        DBG_BP_EN,     // breakpoint armed
   input  wire logic [15:0] DBG_BP_ADDR,   // breakpoint address
   input  wire logic        DBG_WP_EN,     // watchpoint armed
   input  wire logic [7:0]  DBG_WP_ADDR,   // watched data address
   input  wire logic        DBG_MEM_EN,    // debugger memory access
   input  wire logic        DBG_MEM_WE,    // debugger memory write
   input  wire logic [7:0]  DBG_MEM_ADDR,  // debugger address
   input  wire logic [7:0]  DBG_MEM_WDATA, // debugger write byte
   output logic             HALTED,        // core stopped for the debugger
   output logic             DBG_BP_HIT,    // breakpoint stopped a fetch
   output logic             DBG_WP_HIT     // watched address was written
);
   mct_state_t state_r;
   mct_insn_t  insn_r;
   logic [3:0] cnt_r;
   logic [3:0] elap_r;
   logic       step_r;
   logic       accept;
   logic       run_ok;
   logic       bp_match;
   logic       last;
   logic       ram_we;
   logic [7:0] ram_addr;
   logic [7:0] ram_wdata;

   // compare-and-jump is row B, columns 4 to F only; columns 0 to 3 of row B are ordinary opcodes
   function automatic logic op_cjne(input logic [7:0] op);
      return (op[7:4] == 4'hB) && (op[3:2] != 2'b00);
   endfunction

   function automatic logic op_cond(input logic [7:0] op);
      logic r;
      r = 1'b0;
      case (op)
         8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hD5: r = 1'b1;
         default: r = op_cjne(op) || (op[7:3] == 5'b11011);
      endcase
      return r;
   endfunction

   // byte count straight from the standard opcode map
   function automatic logic [1:0] op_len(input logic [7:0] op);
      logic [1:0] l;
      logic [3:0] hi;
      hi = op[7:4];
      l = LEN1;
      if (op[3:0] == 4'h1) begin
         l = LEN2;
      end else if (op[3:0] == 4'h5) begin
         l = (op == 8'hA5) ? LEN1 : LEN2;
      end else if (op[3:0] == 4'h4) begin
         l = ((hi >= 4'h2 && hi <= 4'h7) || hi == 4'h9) ? LEN2 : LEN1;
      end else if (op[3:0] == 4'h2 || op[3:0] == 4'h0) begin
         l = (hi >= 4'h4 && hi <= 4'hD) ? LEN2 : LEN1;
      end
      case (op)
         8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7: l = LEN2;
         default: if (op[7:3] == 5'b01111 || op[7:3] == 5'b10001 ||
                      op[7:3] == 5'b10101 || op[7:3] == 5'b11011) begin
            l = LEN2;
         end
      endcase
      case (op)
         8'h02, 8'h12, 8'h90, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63,
         8'h75, 8'h85, 8'hD5: l = LEN3;
         default: if (op_cjne(op)) begin
            l = LEN3;
         end
      endcase
      return l;
   endfunction

   // clocks follow bytes; indirect, multiply, divide and taken conditional branches are the exceptions
   function automatic logic [3:0] op_cyc(input logic [7:0] op, input logic taken);
      logic [1:0] l;
      logic [3:0] c;
      l = op_len(op);
      c = {2'h0, l};
      if (l == LEN1 && op[3:1] == 3'b011) begin
         c = CYC_IND;
      end
      if (op == OP_MUL) begin
         c = MUL_CYC;
      end
      if (op == OP_DIV) begin
         c = DIV_CYC;
      end
      if (op_cond(op) && taken) begin
         c = c + CYC_ONE;
      end
      if (c > MAX_CYC) begin
         c = MAX_CYC;
      end
      return c;
   endfunction

   // a step lets exactly one instruction out of the halt
   assign run_ok   = !DBG_HALT || step_r;
   assign bp_match = DBG_BP_EN && (FETCH_PC == DBG_BP_ADDR) && !step_r;
   assign last     = (state_r == MCT_EXEC) && (cnt_r == CYC_ONE);
   // accepting on the last clock gives back-to-back issue, one per clock at peak;
   // a halted core takes nothing until a step, even in the cycle after the release
   assign OP_READY = run_ok && !bp_match && (state_r == MCT_IDLE || last || (HALTED && step_r));
   assign accept   = OP_VALID && OP_READY;
   assign INSN_DONE = last;
   assign BUSY     = (state_r == MCT_EXEC);
   assign HALTED   = (state_r == MCT_HALT);
   assign INSN_INFO = insn_r;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         state_r <= MCT_IDLE;
         cnt_r   <= '0;
      end else if (accept) begin
         state_r <= MCT_EXEC;
         cnt_r   <= op_cyc(OP_CODE, COND_TAKEN);
      end else begin
         unique case (state_r)
            MCT_IDLE: if (!run_ok) begin
               state_r <= MCT_HALT;
            end
            MCT_EXEC: if (last) begin
               state_r <= run_ok ? MCT_IDLE : MCT_HALT;
            end else begin
               cnt_r <= cnt_r - CYC_ONE;
            end
            MCT_HALT: if (run_ok) begin
               state_r <= MCT_IDLE;
            end
            default: state_r <= MCT_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         insn_r <= '0;
      end else if (accept) begin
         insn_r.len  <= op_len(OP_CODE);
         insn_r.cyc  <= op_cyc(OP_CODE, COND_TAKEN);
         insn_r.cond <= op_cond(OP_CODE);
      end
   end

   // a new step request wins over the clear caused by issuing
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         step_r <= 1'b0;
      end else if (DBG_STEP) begin
         step_r <= 1'b1;
      end else if (accept) begin
         step_r <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         elap_r <= '0;
      end else if (accept) begin
         elap_r <= CYC_ONE;
      end else if (BUSY) begin
         elap_r <= elap_r + CYC_ONE;
      end
   end

   // debugger owns the RAM port only while halted, so no core state is borrowed
   always_comb begin
      if (HALTED && DBG_MEM_EN) begin
         ram_we    = DBG_MEM_WE;
         ram_addr  = DBG_MEM_ADDR;
         ram_wdata = DBG_MEM_WDATA;
      end else begin
         // direct upper half is the SFR space, indirect reaches all 256 bytes
         ram_we    = DATA_EN && DATA_WE && !(DATA_DIRECT && DATA_ADDR[SFR_BIT]);
         ram_addr  = DATA_ADDR;
         ram_wdata = DATA_WDATA;
      end
   end

   mct_ram256 u_ram (
      .clk     (SYS_CLK),
      .we      (ram_we),
      .addr    (ram_addr),
      .wdata   (ram_wdata),
      .rdata_r (DATA_RDATA)
   );

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         SFR_SEL    <= 1'b0;
         DBG_WP_HIT <= 1'b0;
         DBG_BP_HIT <= 1'b0;
      end else begin
         SFR_SEL    <= DATA_EN && DATA_DIRECT && DATA_ADDR[SFR_BIT];
         DBG_WP_HIT <= DBG_WP_EN && DATA_EN && DATA_WE && (DATA_ADDR == DBG_WP_ADDR);
         DBG_BP_HIT <= OP_VALID && bp_match && run_ok;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         XTGT <= MCT_XT_NONE;
      end else if (CODE_REQ) begin
         XTGT <= MCT_XT_FLASH;
      end else if (XDATA_REQ) begin
         if (FLASH_MAP_EN) begin
            XTGT <= MCT_XT_FLASH;
         end else if (XDATA_ADDR < XRAM_TOP) begin
            XTGT <= MCT_XT_XRAM;
         end else begin
            XTGT <= MCT_XT_EXT;
         end
      end
   end

   sequence s_mul_run;
      !INSN_DONE [*3] ##1 INSN_DONE;
   endsequence

   sequence s_div_run;
      !INSN_DONE [*7] ##1 INSN_DONE;
   endsequence

   AST_CYC_MATCH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      INSN_DONE |-> elap_r == insn_r.cyc) else $error("done clock differs from counted clocks");
   AST_MAX_EIGHT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      BUSY |-> elap_r <= MAX_CYC) else $error("instruction ran past eight clocks");
   AST_LEN_CYC: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      accept && !op_cond(OP_CODE) && OP_CODE[3:1] != 3'b011 && OP_CODE != OP_MUL && OP_CODE != OP_DIV
      |=> insn_r.cyc == {2'h0, insn_r.len}) else $error("clocks differ from bytes");
   AST_BRANCH_GAP: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      accept && op_cond(OP_CODE) |=> insn_r.cyc == {2'h0, insn_r.len} + {3'h0, $past(COND_TAKEN)})
      else $error("branch clock gap wrong");
   AST_MUL_FOUR: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      accept && OP_CODE == OP_MUL |=> s_mul_run) else $error("multiply not four clocks");
   AST_DIV_EIGHT: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      accept && OP_CODE == OP_DIV |=> s_div_run) else $error("divide not eight clocks");
   AST_SFR_DECODE: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      DATA_EN && DATA_DIRECT && DATA_ADDR[SFR_BIT] && !(HALTED && DBG_MEM_EN) |-> !ram_we ##1 SFR_SEL)
      else $error("direct upper access reached RAM");
   AST_XDATA_FLASH: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      XDATA_REQ && FLASH_MAP_EN |=> XTGT == MCT_XT_FLASH) else $error("mapped move missed flash");
   AST_HALT_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      HALTED && !step_r |-> !OP_READY) else $error("halted core took an opcode");
   AST_BACK_TO_BACK: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      last && run_ok && !bp_match |-> OP_READY) else $error("no issue on last clock");
endmodule

// *** testbench/mct_dbg_host.sv ***
// debugger host model driving the halt, step, break, watch and memory pins
`timescale 1ns/1ps
module mct_dbg_host
(
   input  wire logic        clk,       // system clock
   input  wire logic        halted,    // core stopped for us
   output logic             halt,      // hold request
   output logic             step,      // single-step pulse
   output logic             bp_en,     // breakpoint armed
   output logic [15:0]      bp_addr,   // breakpoint address
   output logic             wp_en,     // watchpoint armed
   output logic [7:0]       wp_addr,   // watched address
   output logic             mem_en,    // memory access
   output logic             mem_we,    // memory write
   output logic [7:0]       mem_addr,  // memory address
   output logic [7:0]       mem_wdata  // memory write byte
);
   initial begin
      {halt, step, bp_en, wp_en, mem_en, mem_we} = '0;
      bp_addr = 16'h0000;
      wp_addr = 8'h00;
      mem_addr = 8'h00;
      mem_wdata = 8'h00;
   end
   task automatic set_halt(input logic v);
      @(posedge clk) halt <= v;
   endtask
   task automatic pulse_step;
      @(posedge clk) step <= 1'b1;
      @(posedge clk) step <= 1'b0;
   endtask
   task automatic arm_bp(input logic e, input logic [15:0] a);
      @(posedge clk) bp_en <= e;
      bp_addr <= a;
   endtask
   task automatic arm_wp(input logic e, input logic [7:0] a);
      @(posedge clk) wp_en <= e;
      wp_addr <= a;
   endtask
   // only meaningful while halted; released lines show inverted junk
   task automatic mem_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) mem_en <= halted;
      mem_we <= 1'b1;
      mem_addr <= a;
      mem_wdata <= d;
      @(posedge clk) mem_en <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= ~a;
      mem_wdata <= ~d;
   endtask
endmodule

// *** testbench/mct_core_timing_tb.sv ***
// self-checking bench for the instruction timing core
`timescale 1ns/1ps
module mct_core_timing_tb;
   import mct_pkg::*;
   logic        sys_clk, rst_b, op_valid, cond_taken, data_en, data_we, data_direct;
   logic        xdata_req, flash_map_en, code_req, op_ready, insn_done, busy, sfr_sel;
   logic        halted, bp_hit, wp_hit, d_halt, d_step, d_bp_en, d_wp_en, d_mem_en, d_mem_we;
   logic [7:0]  op_code, data_addr, data_wdata, data_rdata, d_wp_addr, d_mem_addr, d_mem_wdata;
   logic [15:0] fetch_pc, xdata_addr, d_bp_addr;
   mct_insn_t   insn_info;
   mct_xtgt_t   xtgt;
   int          errors, check_count;
   // op, taken, then expected {len, cyc, cond}
   localparam logic [15:0] TBL [14] = '{16'h0022, 16'h0422, 16'h0624, 16'h7444, 16'h7566, 16'hA428,
                                        16'h8430, 16'hA522, 16'h6045, 16'h60C7, 16'hB467, 16'hB4E9,
                                        16'hE422, 16'hD8C7};

   mct_core_timing dut_u (.SYS_CLK(sys_clk), .RST_B(rst_b), .OP_VALID(op_valid), .OP_CODE(op_code),
      .FETCH_PC(fetch_pc), .COND_TAKEN(cond_taken), .OP_READY(op_ready), .INSN_DONE(insn_done),
      .INSN_INFO(insn_info), .BUSY(busy), .DATA_EN(data_en), .DATA_WE(data_we), .DATA_DIRECT(data_direct),
      .DATA_ADDR(data_addr), .DATA_WDATA(data_wdata), .DATA_RDATA(data_rdata), .SFR_SEL(sfr_sel),
      .XDATA_REQ(xdata_req), .XDATA_ADDR(xdata_addr), .FLASH_MAP_EN(flash_map_en), .CODE_REQ(code_req),
      .XTGT(xtgt), .DBG_HALT(d_halt), .DBG_STEP(d_step), .DBG_BP_EN(d_bp_en), .DBG_BP_ADDR(d_bp_addr),
      .DBG_WP_EN(d_wp_en), .DBG_WP_ADDR(d_wp_addr), .DBG_MEM_EN(d_mem_en), .DBG_MEM_WE(d_mem_we),
      .DBG_MEM_ADDR(d_mem_addr), .DBG_MEM_WDATA(d_mem_wdata), .HALTED(halted), .DBG_BP_HIT(bp_hit),
      .DBG_WP_HIT(wp_hit));
   mct_dbg_host host_u (.clk(sys_clk), .halted(halted), .halt(d_halt), .step(d_step), .bp_en(d_bp_en),
      .bp_addr(d_bp_addr), .wp_en(d_wp_en), .wp_addr(d_wp_addr), .mem_en(d_mem_en), .mem_we(d_mem_we),
      .mem_addr(d_mem_addr), .mem_wdata(d_mem_wdata));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // offer one opcode, hold it until taken, then count clocks to completion
   task automatic issue(input logic [15:0] t);
      int n;
      n = 0;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= t[15:8];
      cond_taken <= t[7];
      @(negedge sys_clk);
      while (op_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      op_valid <= 1'b0;
      n = 1;
      @(negedge sys_clk);
      chk("busy", 16'h1, busy);
      while (insn_done !== 1'b1 && n < 12) begin
         @(negedge sys_clk);
         n++;
      end
      chk("cycles", t[4:1], n[15:0]);
      chk("info", t[6:0], insn_info);
   endtask

   task automatic dstep(input logic e, w, d, input logic [7:0] a, wd);
      @(posedge sys_clk);
      data_en <= e;
      data_we <= w;
      data_direct <= d;
      data_addr <= a;
      data_wdata <= wd;
   endtask

   task automatic mv(input logic c, x, fm, input logic [15:0] a, input mct_xtgt_t exp);
      @(posedge sys_clk);
      code_req <= c;
      xdata_req <= x;
      flash_map_en <= fm;
      xdata_addr <= a;
      @(posedge sys_clk);
      code_req <= 1'b0;
      xdata_req <= 1'b0;
      @(negedge sys_clk);
      chk("xtgt", exp, xtgt);
   endtask

   task automatic t_timing;
      foreach (TBL[i]) issue(TBL[i]);
   endtask

   // held request must be taken every clock; the first is taken one edge after it is offered
   task automatic t_b2b;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= 8'h00;
      cond_taken <= 1'b0;
      @(posedge sys_clk);
      repeat (3) begin
         @(negedge sys_clk);
         chk("done", 16'h1, insn_done);
      end
      @(posedge sys_clk);
      op_valid <= 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   // direct writes to the upper half go to the special-function space, not RAM
   task automatic t_data;
      dstep(1, 1, 0, 8'h90, 8'h5A);
      dstep(1, 1, 1, 8'h90, 8'h11);
      @(negedge sys_clk);
      chk("sfr_sel", 16'h0, sfr_sel);
      dstep(1, 0, 0, 8'h90, 8'h00);
      @(negedge sys_clk);
      chk("sfr_sel", 16'h1, sfr_sel);
      dstep(0, 0, 0, 8'h00, 8'h00);
      @(negedge sys_clk);
      chk("rdata", 16'h5A, data_rdata);
   endtask

   task automatic t_moves;
      mv(0, 1, 0, XRAM_TOP - 16'h0001, MCT_XT_XRAM);
      mv(0, 1, 0, XRAM_TOP, MCT_XT_EXT);
      mv(0, 1, 1, 16'h0100, MCT_XT_FLASH);
      mv(1, 0, 0, 16'h0000, MCT_XT_FLASH);
   endtask

   task automatic t_debug;
      fork
         issue(16'hA428);
         begin
            repeat (2) @(negedge sys_clk);
            host_u.set_halt(1'b1);
         end
      join
      chk("halted", 16'h0, halted);
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= 8'h00;
      repeat (3) @(negedge sys_clk);
      chk("halted", 16'h1, halted);
      chk("ready", 16'h0, op_ready);
      host_u.pulse_step();
      repeat (2) @(negedge sys_clk);
      chk("step done", 16'h1, insn_done);
      @(posedge sys_clk);
      op_valid <= 1'b0;
      host_u.mem_write(8'h33, 8'hC3);
      host_u.set_halt(1'b0);
      dstep(1, 0, 0, 8'h33, 8'h00);
      dstep(0, 0, 0, 8'h00, 8'h00);
      @(negedge sys_clk);
      chk("dbg rdata", 16'hC3, data_rdata);
      host_u.arm_wp(1'b1, 8'h40);
      dstep(1, 1, 0, 8'h40, 8'h77);
      dstep(0, 0, 0, 8'h00, 8'h00);
      @(negedge sys_clk);
      chk("wp_hit", 16'h1, wp_hit);
      host_u.arm_wp(1'b0, 8'h40);
   endtask

   task automatic t_break;
      host_u.arm_bp(1'b1, 16'h0123);
      @(posedge sys_clk);
      fetch_pc <= 16'h0123;
      op_valid <= 1'b1;
      @(negedge sys_clk);
      chk("bp ready", 16'h0, op_ready);
      @(negedge sys_clk);
      chk("bp_hit", 16'h1, bp_hit);
      @(posedge sys_clk);
      op_valid <= 1'b0;
      host_u.arm_bp(1'b0, 16'h0123);
      issue(16'h0022);
   endtask

   initial begin
      {rst_b, op_valid, cond_taken, data_en, data_we, data_direct, xdata_req, flash_map_en, code_req} = '0;
      op_code = 8'h00;
      fetch_pc = 16'h0000;
      data_addr = 8'h00;
      data_wdata = 8'h00;
      xdata_addr = 16'h0000;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      chk("rst busy", 16'h0, busy);
      chk("rst xtgt", 16'h0, xtgt);
      chk("rst halted", 16'h0, halted);
      t_timing();
      t_b2b();
      t_data();
      t_moves();
      t_debug();
      t_break();
      report_and_stop();
   end

   // whole run needs well under two thousand clocks
   initial begin
      #100000;
      errors++;
      report_and_stop();
   end
endmodule
